// ==== rtl/cis_pkg.sv ====
// Package for the CPU interrupt sequencer: register map, field layout,
// interrupt source numbering, sequencer states and timing constants.
// Assumes a single 50 MHz clock and a plain register port.
package cis_pkg;

	localparam int CLK_MHZ = 50;
	localparam int NSRC = 8;

	// Source indices in fixed hardware ranking, highest first; the trap, last here, outranks all.
	localparam int SRC_RESET = 0;
	localparam int SRC_NMI = 1;
	localparam int SRC_DBG = 2;
	localparam int SRC_WDT = 3;
	localparam int SRC_PER = 4;
	localparam int SRC_STEP = 5;
	localparam int SRC_AMATCH = 6;
	localparam int SRC_TRAP = 7;

	// Register map (word index on the 4-bit address).
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_FLAGS = 4'h1;
	localparam logic [3:0] REG_USP = 4'h2;
	localparam logic [3:0] REG_ISP = 4'h3;
	localparam logic [3:0] REG_PLVL = 4'h4;
	localparam logic [3:0] REG_PEND = 4'h5;
	localparam logic [3:0] REG_STAT = 4'h6;
	localparam logic [3:0] REG_ACK = 4'h7;
	localparam logic [3:0] REG_PC = 4'h8;
	localparam logic [3:0] REG_TRAP = 4'h9;
	localparam logic [3:0] REG_RETURN = 4'hA;
	localparam logic [3:0] REG_VEC = 4'hB;

	// Flag register field positions and the flag and stack pointer reset values.
	localparam int FLG_STEP = 2;
	localparam int FLG_STACK = 7;
	localparam int FLG_IEN = 6;
	localparam int FLG_PPL_LO = 12;
	localparam logic [15:0] FLG_RESET = 16'h0000;
	localparam logic [15:0] SP_RESET = 16'h0000;

	// Control register fields.
	localparam int CTRL_BUS8 = 0;
	localparam int CTRL_STRING = 1;
	localparam int CTRL_BOUNDARY = 2;

	localparam logic [2:0] LVL_MAX = 3'h7;
	localparam logic [2:0] LVL_RESET = 3'h0;
	localparam logic [5:0] TRAP_KEEP_LO = 6'h20;
	localparam logic [15:0] SP_STEP = 16'h0004;

	// Entry sequence lengths and the longest instruction wait, in cycles.
	localparam logic [4:0] SEQ_EVEN = 5'h12;
	localparam logic [4:0] SEQ_MAX = 5'h14;
	localparam logic [4:0] SEQ_DBG_ADD = 5'h02;
	localparam logic [4:0] SEQ_ONE_ADD = 5'h01;
	localparam logic [4:0] DIVIDE_WAIT_MAX = 5'h1E;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_ACKRD = 3'b001,
		ST_SAVE = 3'b010,
		ST_PUSHF = 3'b011,
		ST_PUSHPC = 3'b100,
		ST_LOAD = 3'b101
	} cis_state_e;

	// Register port request bundle.
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} cis_req_s;

	// Stack write bundle toward the memory bus.
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] data;
		logic [1:0] be;
	} cis_mem_s;

	typedef struct packed {
		cis_state_e state;
		logic [15:0] flags;
		logic [15:0] temp;
		logic [15:0] user_stack_pointer;
		logic [15:0] interrupt_stack_pointer;
		logic [19:0] pc;
		logic [19:0] vec;
		logic [2:0] ctrl;
		logic [23:0] plvl;
		logic [NSRC-1:0] pend;
		logic [2:0] acc_src;
		logic [2:0] acc_lvl;
		logic [5:0] trap_no;
		logic [4:0] cnt;
		logic [4:0] seq_len;
		logic [1:0] wseq;
		logic first_done;
		logic [31:0] rdata;
		cis_mem_s mem;
		logic start;
		logic [7:0] acked;
	} cis_state_s;

endpackage

`default_nettype wire

// ==== rtl/cis_sequencer.sv ====
// CPU interrupt sequencer: arbitration, entry sequence, stack save, return.
// Assumes the core pulses instruction boundaries and, at start_o, takes start_pc_o as the
// new fetch address; stack writes go out as a one-cycle bus strobe.
// Operation
// - Arbitrate at instruction end, enter next cycle.
// - String instructions are suspended for entry.
// - First step reads address zero for info.
// - Save flags, clear enable, step, stack select; the code keeps stack select for trap numbers 6'h20 and up.
// - Push flags, push PC, load priority level.
// - Fixed sources set level seven, zero, unchanged.
// - After entry fetch from routine start.
// - Entry lasts 18, 19 or 20 cycles.
// - Debug break adds two, step/match add one.
// - Longest instruction wait is 30 cycles.
// - Only flags and PC saved, packed words.
// - Odd stack pointer uses byte writes; minus four.
// - Return restores flags and PC.
// - Highest priority wins; ties by fixed rank.
// - Rank: reset, nmi, debug, watchdog, peripheral, step, match.
// - Traps bypass arbitration, always branch.
// - Entry clears enable and accepted request flag.
// - Refused requests stay pending; strictly higher wins.
// - Program read of zero clears top request.
// - Reset zeroes stack pointers; first instruction blocked.
// - Maskable needs enable, request, level above.
// - Requests set by hardware, cleared never set.
// - Three-bit level, zero disables, seven highest.
`timescale 1ns/100ps
`default_nettype none

module cis_sequencer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire cis_pkg::cis_req_s req_i,
	input wire logic [cis_pkg::NSRC-1:0] irq_i,
	input wire logic insn_done_i,
	input wire logic [19:0] pc_i,
	input wire logic [19:0] vector_i,
	output logic [31:0] rdata_o,
	output cis_pkg::cis_mem_s mem_o,
	output logic entry_busy_o,
	output logic start_o,
	output logic [19:0] start_pc_o
);

	cis_pkg::cis_state_s s_r;
	cis_pkg::cis_state_s s_nxt;
	logic [19:0] start_pc_r;
	logic busy_r;

	// Arbitration results, combinational.
	logic [cis_pkg::NSRC-1:0] elig;
	logic [2:0] win_src;
	logic [2:0] win_lvl;
	logic win_any;
	logic [2:0] top_src;
	logic top_any;
	logic boundary;
	logic [15:0] sp_act;
	logic [2:0] plvl_now;

	assign plvl_now = s_r.flags[cis_pkg::FLG_PPL_LO +: 3];
	assign sp_act = s_r.flags[cis_pkg::FLG_STACK] ? s_r.user_stack_pointer : s_r.interrupt_stack_pointer;

	// Eligibility per source; level 0 disables maskable ones.
	generate
		for (genvar g = 0; g < cis_pkg::NSRC; g++) begin : g_elig
			if (g == cis_pkg::SRC_PER) begin : g_mask
				assign elig[g] = s_r.pend[g] && s_r.flags[cis_pkg::FLG_IEN] &&
					(s_r.plvl[3*g +: 3] > plvl_now);
			end else if (g == cis_pkg::SRC_TRAP) begin : g_trap
				assign elig[g] = s_r.pend[g];
			end else begin : g_fix
				assign elig[g] = s_r.pend[g];
			end
		end
	endgenerate

	// The string enable lets entry cut into long instructions; the boundary bit is not used.
	// A long divide only delays insn_done_i, so its wait needs no counter.
	assign boundary = insn_done_i || s_r.ctrl[cis_pkg::CTRL_STRING];

	// Fixed ranking: lowest index wins; traps always outrank sampling.
	always_comb begin
		win_src = 3'h0;
		win_any = 1'b0;
		if (elig[cis_pkg::SRC_TRAP]) begin
			win_src = 3'(cis_pkg::SRC_TRAP);
			win_any = 1'b1;
		end else begin
			for (int i = cis_pkg::NSRC - 2; i >= 0; i--) begin
				if (elig[i]) begin
					win_src = 3'(i);
					win_any = 1'b1;
				end
			end
		end
	end

	// Highest-ranked pending request other than the trap, regardless of the interrupt enable and level.
	always_comb begin
		top_src = 3'h0;
		top_any = 1'b0;
		for (int i = cis_pkg::NSRC - 2; i >= 0; i--) begin
			if (s_r.pend[i]) begin
				top_src = 3'(i);
				top_any = 1'b1;
			end
		end
	end

	// Level loaded on entry by source type.
	always_comb begin
		case (win_src)
			3'(cis_pkg::SRC_NMI), 3'(cis_pkg::SRC_WDT): win_lvl = cis_pkg::LVL_MAX;
			3'(cis_pkg::SRC_RESET): win_lvl = cis_pkg::LVL_RESET;
			3'(cis_pkg::SRC_PER): win_lvl = s_r.plvl[3*cis_pkg::SRC_PER +: 3];
			default: win_lvl = plvl_now;
		endcase
	end

	// Next state of the whole sequencer.
	always_comb begin
		logic [4:0] len;
		logic odd_sp;
		logic [15:0] sp_new;
		len = cis_pkg::SEQ_EVEN;
		odd_sp = 1'b0;
		sp_new = 16'h0000;
		s_nxt = s_r;
		s_nxt.mem.valid = 1'b0;
		s_nxt.start = 1'b0;
		s_nxt.rdata = 32'h0000_0000;
		s_nxt.pend = s_r.pend | irq_i;
		if (insn_done_i) begin
			s_nxt.first_done = 1'b1;
		end

		// Register port writes; set beats clear on pending bits.
		if (req_i.wr) begin
			case (req_i.addr)
				cis_pkg::REG_CTRL: s_nxt.ctrl = req_i.wdata[2:0];
				cis_pkg::REG_FLAGS: s_nxt.flags = req_i.wdata[15:0];
				cis_pkg::REG_USP: s_nxt.user_stack_pointer = req_i.wdata[15:0];
				cis_pkg::REG_ISP: s_nxt.interrupt_stack_pointer = req_i.wdata[15:0];
				cis_pkg::REG_PLVL: s_nxt.plvl = req_i.wdata[23:0];
				cis_pkg::REG_PEND: begin
					s_nxt.pend = (s_r.pend & req_i.wdata[7:0]) | irq_i;
				end
				cis_pkg::REG_TRAP: begin
					s_nxt.trap_no = req_i.wdata[5:0];
					s_nxt.pend[cis_pkg::SRC_TRAP] = 1'b1;
				end
				cis_pkg::REG_RETURN: begin
					s_nxt.flags = req_i.wdata[15:0];
					s_nxt.start = 1'b1;
				end
				default: ;
			endcase
		end

		// Register port reads; data stand the cycle after the strobe.
		if (req_i.rd) begin
			case (req_i.addr)
				cis_pkg::REG_CTRL: s_nxt.rdata = {29'h0, s_r.ctrl};
				cis_pkg::REG_FLAGS: s_nxt.rdata = {16'h0, s_r.flags};
				cis_pkg::REG_USP: s_nxt.rdata = {16'h0, s_r.user_stack_pointer};
				cis_pkg::REG_ISP: s_nxt.rdata = {16'h0, s_r.interrupt_stack_pointer};
				cis_pkg::REG_PLVL: s_nxt.rdata = {8'h0, s_r.plvl};
				cis_pkg::REG_PEND: s_nxt.rdata = {24'h0, s_r.pend};
				cis_pkg::REG_STAT: s_nxt.rdata = {19'h0, s_r.seq_len,
					5'(s_r.state), s_r.acc_lvl};
				cis_pkg::REG_ACK: begin
					s_nxt.rdata = {24'h0, top_any, s_r.plvl[3*top_src +: 3],
						top_src, 1'b0};
					if (top_any) begin
						s_nxt.pend[top_src] = irq_i[top_src];
					end
				end
				cis_pkg::REG_PC: s_nxt.rdata = {12'h0, s_r.pc};
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// Entry sequence; counts keep the documented total length.
		case (s_r.state)
			cis_pkg::ST_RUN: begin
				// A trap is the executing instruction, so it needs no boundary.
				if (win_any && s_r.first_done && (boundary ||
					win_src == 3'(cis_pkg::SRC_TRAP))) begin
					s_nxt.state = cis_pkg::ST_ACKRD;
					s_nxt.acc_src = win_src;
					s_nxt.acc_lvl = win_lvl;
					s_nxt.pc = pc_i;
					s_nxt.vec = vector_i;
					odd_sp = sp_act[0];
					if (s_r.ctrl[cis_pkg::CTRL_BUS8]) begin
						len = cis_pkg::SEQ_MAX;
					end else begin
						len = cis_pkg::SEQ_EVEN + 5'(odd_sp) + 5'(vector_i[0]);
					end
					if (win_src == 3'(cis_pkg::SRC_DBG)) begin
						len = len + cis_pkg::SEQ_DBG_ADD;
					end else if (win_src == 3'(cis_pkg::SRC_STEP) ||
						win_src == 3'(cis_pkg::SRC_AMATCH)) begin
						len = len + cis_pkg::SEQ_ONE_ADD;
					end
					s_nxt.seq_len = len;
					s_nxt.cnt = len;
				end
			end
			cis_pkg::ST_ACKRD: begin
				// Acknowledge read of address zero clears the request.
				s_nxt.pend[s_r.acc_src] = irq_i[s_r.acc_src];
				s_nxt.state = cis_pkg::ST_SAVE;
				s_nxt.cnt = s_r.cnt - 5'h01;
			end
			cis_pkg::ST_SAVE: begin
				s_nxt.temp = s_r.flags;
				s_nxt.flags[cis_pkg::FLG_IEN] = 1'b0;
				s_nxt.flags[cis_pkg::FLG_STEP] = 1'b0;
				if (!(s_r.acc_src == 3'(cis_pkg::SRC_TRAP) &&
					s_r.trap_no >= cis_pkg::TRAP_KEEP_LO)) begin
					s_nxt.flags[cis_pkg::FLG_STACK] = 1'b0;
				end
				s_nxt.wseq = 2'h0;
				s_nxt.state = cis_pkg::ST_PUSHF;
				s_nxt.cnt = s_r.cnt - 5'h01;
			end
			cis_pkg::ST_PUSHF, cis_pkg::ST_PUSHPC: begin
				sp_new = sp_act - 16'h0002;
				s_nxt.mem.valid = 1'b1;
				s_nxt.cnt = s_r.cnt - 5'h01;
				// Flags word pairs PC[19:16] with flag high nibble and low byte.
				s_nxt.mem.data = (s_r.state == cis_pkg::ST_PUSHF) ?
					{s_r.temp[15:12], s_r.pc[19:16], s_r.temp[7:0]} :
					s_r.pc[15:0];
				if (!sp_act[0]) begin
					s_nxt.mem.addr = sp_new;
					s_nxt.mem.be = 2'b11;
					s_nxt.wseq = 2'h2;
				end else begin
					// Odd pointer: high byte then low byte.
					s_nxt.mem.addr = sp_act - 16'(s_r.wseq) - 16'h0001;
					s_nxt.mem.be = s_r.wseq[0] ? 2'b01 : 2'b10;
					s_nxt.wseq = s_r.wseq + 2'h1;
				end
				if (s_nxt.wseq == 2'h2) begin
					s_nxt.wseq = 2'h0;
					if (s_r.flags[cis_pkg::FLG_STACK]) begin
						s_nxt.user_stack_pointer = sp_new;
					end else begin
						s_nxt.interrupt_stack_pointer = sp_new;
					end
					s_nxt.state = (s_r.state == cis_pkg::ST_PUSHF) ?
						cis_pkg::ST_PUSHPC : cis_pkg::ST_LOAD;
				end
			end
			cis_pkg::ST_LOAD: begin
				s_nxt.flags[cis_pkg::FLG_PPL_LO +: 3] = s_r.acc_lvl;
				s_nxt.cnt = s_r.cnt - 5'h01;
				// Pad to the documented length before releasing the core.
				if (s_r.cnt <= 5'h01) begin
					s_nxt.state = cis_pkg::ST_RUN;
					s_nxt.start = 1'b1;
					s_nxt.first_done = 1'b1;
				end
			end
			default: s_nxt.state = cis_pkg::ST_RUN;
		endcase
	end

	// Register the state; reset clears stack pointers and the first-fetch mark.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.state <= cis_pkg::ST_RUN;
			s_r.flags <= cis_pkg::FLG_RESET;
			s_r.user_stack_pointer <= cis_pkg::SP_RESET;
			s_r.interrupt_stack_pointer <= cis_pkg::SP_RESET;
			s_r.first_done <= 1'b0;
			start_pc_r <= 20'h00000;
			busy_r <= 1'b0;
		end else begin
			s_r <= s_nxt;
			busy_r <= (s_nxt.state != cis_pkg::ST_RUN);
			if (s_nxt.start && s_r.state == cis_pkg::ST_LOAD) begin
				start_pc_r <= s_r.vec;
			end else if (req_i.wr && req_i.addr == cis_pkg::REG_RETURN) begin
				start_pc_r <= req_i.wdata[31:12];
			end
		end
	end

	assign rdata_o = s_r.rdata;
	assign mem_o = s_r.mem;
	assign start_o = s_r.start;
	assign start_pc_o = start_pc_r;
	assign entry_busy_o = busy_r;

endmodule // cis_sequencer

`default_nettype wire

// ==== testbench/cis_sequencer_properties.sv ====
// Concurrent checks on the ports of the interrupt sequencer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module cis_seq_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire cis_pkg::cis_req_s req_i,
	input wire logic [cis_pkg::NSRC-1:0] irq_i,
	input wire logic insn_done_i,
	input wire logic [19:0] pc_i,
	input wire logic [19:0] vector_i,
	input wire logic [31:0] rdata_o,
	input wire cis_pkg::cis_mem_s mem_o,
	input wire logic entry_busy_o,
	input wire logic start_o,
	input wire logic [19:0] start_pc_o
);
	logic seen_r;
	logic [5:0] busy_cnt_r;
	// Note the first boundary and the length of each entry run.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seen_r <= 1'b0;
			busy_cnt_r <= 6'h00;
		end else begin
			seen_r <= seen_r | insn_done_i;
			busy_cnt_r <= entry_busy_o ? busy_cnt_r + 6'h01 : 6'h00;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_first_blocked: assert property (!seen_r |-> !entry_busy_o)
		else $error("entry before the first instruction ended");
	a_start_pulse: assert property (start_o |=> !start_o)
		else $error("start strobe longer than one cycle");
	a_start_vector: assert property (
		start_o && $past(entry_busy_o) |-> start_pc_o == vector_i)
		else $error("entry start address is not the routine address");
	a_entry_length: assert property (
		$rose(entry_busy_o) |-> !start_o [*8] ##[10:15] start_o)
		else $error("entry length outside its bounds");
	a_push_in_entry: assert property (mem_o.valid |-> entry_busy_o)
		else $error("stack write outside an entry");
	a_push_soon: assert property (
		$rose(entry_busy_o) |-> ##[1:12] mem_o.valid)
		else $error("entry without a stack write");
	a_word_even: assert property (
		mem_o.valid && mem_o.be == 2'h3 |-> !mem_o.addr[0])
		else $error("word stack write at an odd address");
	a_busy_bound: assert property (busy_cnt_r <= 6'h17)
		else $error("entry sequence ran too long");
	// The three main paths: an entry, byte pushes and a return.
	c_entry: cover property ($rose(entry_busy_o));
	c_byte_push: cover property (mem_o.valid && mem_o.be == 2'h2);
	c_return: cover property (start_o && !$past(entry_busy_o));
endmodule // cis_seq_props
bind cis_sequencer cis_seq_props u_cis_seq_props (
	.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .irq_i(irq_i),
	.insn_done_i(insn_done_i), .pc_i(pc_i), .vector_i(vector_i),
	.rdata_o(rdata_o), .mem_o(mem_o), .entry_busy_o(entry_busy_o),
	.start_o(start_o), .start_pc_o(start_pc_o));
`default_nettype wire

// ==== testbench/cis_stack_mem.sv ====
// Memory bus side model: logs every stack write the sequencer issues.
// Assumes each write is a one-cycle strobe sampled on the rising edge.
`timescale 1ns/100ps
`default_nettype none
module cis_stack_mem (
	input wire logic clk_i,
	input wire cis_pkg::cis_mem_s mem_i
);
	cis_pkg::cis_mem_s log_q[$];
	// Lanes are kept as issued so the bench can judge the split.
	always @(posedge clk_i) begin
		if (mem_i.valid) begin
			log_q.push_back(mem_i);
		end
	end
endmodule // cis_stack_mem
`default_nettype wire

// ==== testbench/cpu_interrupt_sequencer_test.sv ====
// Self-checking bench for the interrupt sequencer.
// Assumes the stack memory model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module cpu_interrupt_sequencer_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	cis_pkg::cis_req_s req_i = '0;
	logic [7:0] irq_i = 8'h00;
	logic insn_done_i = 1'b0;
	logic [19:0] pc_i = 20'h00000;
	logic [19:0] vector_i = 20'h00000;
	logic [31:0] rdata_o;
	cis_pkg::cis_mem_s mem_o;
	logic entry_busy_o;
	logic start_o;
	logic [19:0] start_pc_o;
	int miscompares = 0;
	int cmp_count = 0;
	int n;
	logic [15:0] sp;
	logic [2:0] lvl;
	logic [31:0] rv;
	logic [31:0] ret;
	logic [5:0] traps [2] = '{6'h05, 6'h28};

	cis_sequencer u_cis_sequencer (
		.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .irq_i(irq_i),
		.insn_done_i(insn_done_i), .pc_i(pc_i), .vector_i(vector_i),
		.rdata_o(rdata_o), .mem_o(mem_o), .entry_busy_o(entry_busy_o),
		.start_o(start_o), .start_pc_o(start_pc_o));
	cis_stack_mem u_cis_stack_mem (.clk_i(clk_i), .mem_i(mem_o));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Bus cycles hold every field until the strobe edge has passed.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_i);
		req_i.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		req_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_i);
		req_i.rd <= 1'b0;
		#1 rv = rdata_o;
	endtask
	task automatic pulse(input logic [7:0] irq, input logic done);
		@(posedge clk_i);
		irq_i <= irq;
		insn_done_i <= done;
		@(posedge clk_i);
		irq_i <= 8'h00;
		insn_done_i <= 1'b0;
	endtask
	// Bounded wait so a missing start strobe cannot hang the run.
	task automatic wait_start();
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			#1;
		end while (start_o !== 1'b1 && n < 40);
	endtask
	task automatic entry(input int len);
		pulse(8'h00, 1'b1);
		wait_start();
		check(32'(n), 32'(len));
		check({12'h0, start_pc_o}, {12'h0, vector_i});
	endtask
	task automatic final_report();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Free-running 50 MHz clock.
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// The whole run needs well under a thousand cycles.
	initial begin
		#100000;
		miscompares++;
		final_report();
	end
	initial begin
		void'($urandom(7522));
		pc_i = 20'($urandom());
		vector_i = 20'($urandom()) & 20'hFFFFE;
		sp = (16'($urandom()) & 16'hFFFE) | 16'h0100;
		lvl = 3'($urandom_range(7, 1));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(cis_pkg::REG_ISP);
		check(rv, 32'h0);
		rd(cis_pkg::REG_USP);
		check(rv, 32'h0);
		wr(cis_pkg::REG_PLVL, 32'(lvl) << 12);
		wr(cis_pkg::REG_FLAGS, 32'h40);
		wr(cis_pkg::REG_ISP, {16'h0, sp});
		pulse(8'h00, 1'b1);
		// A request waits for the boundary, then the stack is filled.
		pulse(8'h10, 1'b0);
		repeat (3) @(posedge clk_i);
		check({31'h0, entry_busy_o}, 32'h0);
		entry(18);
		check(32'(u_cis_stack_mem.log_q.size()), 32'h2);
		check({u_cis_stack_mem.log_q[0].addr, u_cis_stack_mem.log_q[0].data},
			{sp - 16'h2, 4'h0, pc_i[19:16], 8'h40});
		check({u_cis_stack_mem.log_q[1].addr, u_cis_stack_mem.log_q[1].data},
			{sp - 16'h4, pc_i[15:0]});
		rd(cis_pkg::REG_FLAGS);
		check(rv, 32'(lvl) << 12);
		rd(cis_pkg::REG_PEND);
		check(rv, 32'h0);
		rd(cis_pkg::REG_ISP);
		check(rv, {16'h0, sp - 16'h4});
		// Same level is refused, stays pending and cannot be set by writes.
		wr(cis_pkg::REG_FLAGS, 32'h40 | (32'(lvl) << 12));
		pulse(8'h10, 1'b1);
		repeat (25) @(posedge clk_i);
		rd(cis_pkg::REG_PEND);
		check(rv, 32'h10);
		wr(cis_pkg::REG_PEND, 32'hFF);
		rd(cis_pkg::REG_PEND);
		check(rv, 32'h10);
		ret = {16'($urandom()), 1'b0, lvl - 3'h1, 12'h040};
		wr(cis_pkg::REG_RETURN, ret);
		#1;
		check({31'h0, start_o}, 32'h1);
		check({12'h0, start_pc_o}, {12'h0, ret[31:12]});
		entry(18);
		// Odd stack pointer: byte pushes and level seven for the NMI.
		wr(cis_pkg::REG_ISP, {16'h0, sp | 16'h1});
		u_cis_stack_mem.log_q.delete();
		pulse(8'h02, 1'b0);
		entry(19);
		check(32'(u_cis_stack_mem.log_q.size()), 32'h4);
		rd(cis_pkg::REG_FLAGS);
		check(rv, 32'h7000);
		rd(cis_pkg::REG_ISP);
		check(rv, {16'h0, (sp | 16'h1) - 16'h4});
		// Watchdog beats a peripheral sampled with it; odd vector.
		wr(cis_pkg::REG_FLAGS, 32'h40);
		wr(cis_pkg::REG_ISP, {16'h0, sp});
		vector_i <= vector_i | 20'h00001;
		pulse(8'h18, 1'b0);
		entry(19);
		rd(cis_pkg::REG_FLAGS);
		check(rv, 32'h7000);
		rd(cis_pkg::REG_PEND);
		check(rv, 32'h10);
		vector_i <= vector_i & 20'hFFFFE;
		// Byte-wide bus with a debugger break, then a suspended string.
		wr(cis_pkg::REG_CTRL, 32'h1);
		pulse(8'h04, 1'b0);
		entry(22);
		rd(cis_pkg::REG_FLAGS);
		check(rv, 32'h7000);
		wr(cis_pkg::REG_CTRL, 32'h2);
		pulse(8'h02, 1'b0);
		wait_start();
		check({31'h0, start_o}, 32'h1);
		wr(cis_pkg::REG_CTRL, 32'h0);
		rd(cis_pkg::REG_ACK);
		check(rv, 32'h88 | (32'(lvl) << 4));
		rd(cis_pkg::REG_PEND);
		check(rv, 32'h0);
		// Low traps clear the stack select flag, high traps keep it.
		for (int i = 0; i < 2; i++) begin
			wr(cis_pkg::REG_FLAGS, 32'h80);
			wr(cis_pkg::REG_USP, {16'h0, sp});
			wr(cis_pkg::REG_TRAP, {26'h0, traps[i]});
			wait_start();
			check({31'h0, start_o}, 32'h1);
			rd(cis_pkg::REG_FLAGS);
			check(rv & 32'hC0, (traps[i] >= 6'h20) ? 32'h80 : 32'h0);
		end
		final_report();
	end
endmodule // cpu_interrupt_sequencer_test
`default_nettype wire
